// >>> rtl/rbs_pkg.sv
package rbs_pkg;

  // register map, byte addresses on the avalon slave
  localparam int RBS_ADDR_W = 10;
  localparam logic [9:0] RBS_REG_ACC = 10'h000;
  localparam logic [9:0] RBS_REG_FLAGS = 10'h004;
  localparam logic [9:0] RBS_REG_CMD = 10'h008;
  localparam logic [9:0] RBS_REG_STAT = 10'h00c;
  localparam logic [9:0] RBS_MEM_BASE = 10'h100;
  localparam int RBS_MEM_DEPTH = 64;
  localparam int RBS_PTR_W = 6;

  // flag bit positions in the flags register
  localparam int RBS_FLG_C = 0;
  localparam int RBS_FLG_AC = 1;
  localparam int RBS_FLG_Z = 2;
  localparam int RBS_FLG_OV = 3;

  // command register fields
  localparam int RBS_CMD_OP_LSB = 0;
  localparam int RBS_CMD_PTR_LSB = 8;

  // status register fields
  localparam int RBS_STAT_BUSY = 3;
  localparam int RBS_STAT_BAD = 4;

  // operation codes written to the command register
  localparam logic [2:0] RBS_OP_ROT_COPY = 3'h0;
  localparam logic [2:0] RBS_OP_ROT_CARRY = 3'h1;
  localparam logic [2:0] RBS_OP_ROT_CARRY_COPY = 3'h2;
  localparam logic [2:0] RBS_OP_SUB_BORROW = 3'h3;
  localparam logic [2:0] RBS_OP_SUB_BORROW_MEM = 3'h4;
  localparam logic [2:0] RBS_OP_COUNT = 3'h5;

  // reset values
  localparam logic [7:0] RBS_ACC_RST = 8'h00;
  localparam logic [3:0] RBS_FLG_RST = 4'h0;
  localparam logic [7:0] RBS_MEM_RST = 8'h00;

  // cycles spent in the execute state per command
  localparam int RBS_EXEC_CYCLES = 1;

endpackage

// >>> rtl/rbs_alu_if.sv
`timescale 1ns/10ps
interface rbs_alu_if;
  logic [2:0] op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic carry;
  logic [7:0] res;
  logic wr_acc;
  logic wr_mem;
  logic wr_carry;
  logic wr_arith;
  logic [3:0] flags;

  modport core
  (
    output op,
    output acc,
    output mem,
    output carry,
    input res,
    input wr_acc,
    input wr_mem,
    input wr_carry,
    input wr_arith,
    input flags
  );

  modport alu
  (
    input op,
    input acc,
    input mem,
    input carry,
    output res,
    output wr_acc,
    output wr_mem,
    output wr_carry,
    output wr_arith,
    output flags
  );
endinterface

// >>> rtl/rbs_alu.sv
`timescale 1ns/10ps
module rbs_alu
(
  // operands in, results out
  rbs_alu_if.alu bus
);
  import rbs_pkg::*;

  // nine-bit right rotation of byte and carry: {carry, byte}
  function automatic logic [8:0] rot_carry(input logic [7:0] b,
                                           input logic c);
    rot_carry = {b[0], c, b[7:1]};
  endfunction

  logic [8:0] diff;
  logic [4:0] nib;
  logic [8:0] rot;

  always_comb
  begin
    // carry is an inverted borrow: subtract the complement of carry
    diff = {1'b0, bus.acc} - {1'b0, bus.mem} - {8'h00, ~bus.carry};
    nib = {1'b0, bus.acc[3:0]} - {1'b0, bus.mem[3:0]} - {4'h0, ~bus.carry};
    rot = rot_carry(bus.mem, bus.carry);
    bus.res = 8'h00;
    bus.wr_acc = 1'b0;
    bus.wr_mem = 1'b0;
    bus.wr_carry = 1'b0;
    bus.wr_arith = 1'b0;
    bus.flags = 4'h0;
    case (bus.op)
      RBS_OP_ROT_COPY:
      begin
        bus.res = {bus.mem[0], bus.mem[7:1]}; // [RULE1]
        bus.wr_acc = 1'b1; // [RULE1]
      end
      RBS_OP_ROT_CARRY:
      begin
        bus.res = rot[7:0]; // [RULE2]
        bus.wr_mem = 1'b1; // [RULE2]
        bus.wr_carry = 1'b1; // [RULE2]
        bus.flags[RBS_FLG_C] = rot[8]; // [RULE2]
      end
      RBS_OP_ROT_CARRY_COPY:
      begin
        bus.res = rot[7:0]; // [RULE3]
        bus.wr_acc = 1'b1; // [RULE3]
        bus.wr_carry = 1'b1;
        bus.flags[RBS_FLG_C] = rot[8]; // [RULE3]
      end
      RBS_OP_SUB_BORROW, RBS_OP_SUB_BORROW_MEM:
      begin
        bus.res = diff[7:0]; // [RULE4] [RULE6]
        bus.wr_acc = (bus.op == RBS_OP_SUB_BORROW); // [RULE4]
        bus.wr_mem = (bus.op == RBS_OP_SUB_BORROW_MEM); // [RULE6]
        bus.wr_arith = 1'b1; // [RULE4] [RULE6]
        bus.flags[RBS_FLG_C] = ~diff[8]; // [RULE5]
        bus.flags[RBS_FLG_AC] = ~nib[4]; // [RULE7]
        bus.flags[RBS_FLG_Z] = (diff[7:0] == 8'h00); // [RULE7]
        bus.flags[RBS_FLG_OV] = (bus.acc[7] ^ bus.mem[7]) &
                                (bus.acc[7] ^ diff[7]); // [RULE7]
      end
      default:
      begin
        bus.res = 8'h00;
      end
    endcase
  end
endmodule

// >>> rtl/rbs_core.sv
// Operation
// RULE1: rotate copy: accumulator gets memory rotated right
// RULE2: rotate through carry, written back to memory
// RULE3: rotate through carry, result into accumulator
// RULE4: accumulator minus operand minus inverted carry
// RULE5: carry cleared on negative, set otherwise
// RULE6: same subtraction, result into data memory
// RULE7: zero, signed overflow, nibble inverted borrow flags
`timescale 1ns/10ps
module rbs_core
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // avalon-mm slave
  input wire logic [rbs_pkg::RBS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // observation
  output logic [7:0] acc_o,
  output logic [3:0] flags_o,
  output logic busy_o
);
  import rbs_pkg::*;

  typedef enum logic [1:0]
  {
    st_idle,
    st_exec
  } rbs_state_t;

  // true when the byte address is word aligned and falls in the data memory window
  function automatic logic in_mem(input logic [RBS_ADDR_W-1:0] a);
    in_mem = (a >= RBS_MEM_BASE) &&
             (a < RBS_MEM_BASE + 10'(RBS_MEM_DEPTH * 4)) &&
             (a[1:0] == 2'b00);
  endfunction

  // word index of a byte address inside the memory window
  function automatic logic [RBS_PTR_W-1:0] mem_idx(
    input logic [RBS_ADDR_W-1:0] a);
    logic [RBS_ADDR_W-1:0] off;
    off = a - RBS_MEM_BASE;
    mem_idx = off[RBS_PTR_W+1:2];
  endfunction

  rbs_alu_if alu_if ();

  rbs_alu u_alu
  (
    .bus(alu_if.alu)
  );

  rbs_state_t st_q;
  rbs_state_t st_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [3:0] flg_q;
  logic [3:0] flg_d;
  logic [2:0] op_q;
  logic [2:0] op_d;
  logic [RBS_PTR_W-1:0] ptr_q;
  logic [RBS_PTR_W-1:0] ptr_d;
  logic bad_q;
  logic bad_d;
  logic [7:0] mem_q [RBS_MEM_DEPTH];
  logic mem_we;
  logic [RBS_PTR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic req;
  logic take_wr;
  logic exec;
  logic [2:0] new_op;

  // bus handshake: every access waits one cycle so read data come
  // from a flop; accesses stall while a command executes
  always_comb
  begin
    req = avs_read_i | avs_write_i;
    ack_d = req & ~ack_q & (st_q == st_idle);
    take_wr = avs_write_i & ack_q;
    exec = (st_q == st_exec);
    new_op = avs_writedata_i[RBS_CMD_OP_LSB +: 3];
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
    end
  end

  // read data latched on the edge that raises the acknowledge
  always_comb
  begin
    rdata_d = rdata_q;
    if (avs_read_i && !ack_q && st_q == st_idle)
    begin
      rdata_d = 32'h0000_0000;
      if (in_mem(avs_address_i))
      begin
        rdata_d = {24'h00_0000, mem_q[mem_idx(avs_address_i)]};
      end
      else
      begin
        case (avs_address_i)
          RBS_REG_ACC: rdata_d = {24'h00_0000, acc_q};
          RBS_REG_FLAGS: rdata_d = {28'h000_0000, flg_q};
          RBS_REG_CMD:
          begin
            rdata_d = 32'h0000_0000;
            rdata_d[RBS_CMD_OP_LSB +: 3] = op_q;
            rdata_d[RBS_CMD_PTR_LSB +: RBS_PTR_W] = ptr_q;
          end
          RBS_REG_STAT:
          begin
            rdata_d = 32'h0000_0000;
            rdata_d[RBS_STAT_BUSY] = exec;
            rdata_d[RBS_STAT_BAD] = bad_q;
          end
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // command launch and sequencing
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    ptr_d = ptr_q;
    bad_d = bad_q;
    case (st_q)
      st_idle:
      begin
        if (take_wr && avs_address_i == RBS_REG_CMD)
        begin
          if (avs_byteenable_i[1])
          begin
            ptr_d = avs_writedata_i[RBS_CMD_PTR_LSB +: RBS_PTR_W];
          end
          if (avs_byteenable_i[0])
          begin
            op_d = new_op;
            // an unknown code is still stored in the op field but is refused and marks the status
            if (new_op < RBS_OP_COUNT)
            begin
              bad_d = 1'b0;
              st_d = st_exec;
            end
            else
            begin
              bad_d = 1'b1;
            end
          end
        end
      end
      st_exec:
      begin
        st_d = st_idle;
      end
      default:
      begin
        st_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_q <= st_idle;
      op_q <= RBS_OP_ROT_COPY;
      ptr_q <= '0;
      bad_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      ptr_q <= ptr_d;
      bad_q <= bad_d;
    end
  end

  // operands feed the datapath at all times; its results are used only while executing
  always_comb
  begin
    alu_if.op = op_q;
    alu_if.acc = acc_q;
    alu_if.mem = mem_q[ptr_q];
    alu_if.carry = flg_q[RBS_FLG_C];
  end

  // accumulator and flags: software writes only land while idle, so
  // they never meet a result of the datapath in the same cycle
  always_comb
  begin
    acc_d = acc_q;
    flg_d = flg_q;
    if (exec)
    begin
      if (alu_if.wr_acc)
      begin
        acc_d = alu_if.res; // [RULE1] [RULE3] [RULE4]
      end
      if (alu_if.wr_arith)
      begin
        flg_d = alu_if.flags; // [RULE4] [RULE5] [RULE6] [RULE7]
      end
      else if (alu_if.wr_carry)
      begin
        flg_d[RBS_FLG_C] = alu_if.flags[RBS_FLG_C]; // [RULE2] [RULE3]
      end
    end
    else if (take_wr && avs_byteenable_i[0])
    begin
      if (avs_address_i == RBS_REG_ACC)
      begin
        acc_d = avs_writedata_i[7:0];
      end
      if (avs_address_i == RBS_REG_FLAGS)
      begin
        flg_d = avs_writedata_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      acc_q <= RBS_ACC_RST;
      flg_q <= RBS_FLG_RST;
    end
    else
    begin
      acc_q <= acc_d;
      flg_q <= flg_d;
    end
  end

  // data memory: one write port shared by the bus and the datapath
  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = ptr_q;
    mem_wd = alu_if.res;
    if (exec)
    begin
      mem_we = alu_if.wr_mem; // [RULE2] [RULE6]
    end
    else if (take_wr && avs_byteenable_i[0] && in_mem(avs_address_i))
    begin
      mem_we = 1'b1;
      mem_wa = mem_idx(avs_address_i);
      mem_wd = avs_writedata_i[7:0];
    end
  end

  // memory contents are cleared by reset so reads are never unknown
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < RBS_MEM_DEPTH; i++)
      begin
        mem_q[i] <= RBS_MEM_RST;
      end
    end
    else if (mem_we)
    begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // outputs
  always_comb
  begin
    avs_waitrequest_o = req & ~ack_q;
    avs_readdata_o = rdata_q;
    acc_o = acc_q;
    flags_o = flg_q;
    busy_o = exec;
  end

endmodule

// >>> verification/rbs_core_props.sv
`timescale 1ns/10ps
module rbs_core_chk
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // avalon-mm slave
  input wire logic [rbs_pkg::RBS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // observation
  input wire logic [7:0] acc_o,
  input wire logic [3:0] flags_o,
  input wire logic busy_o
);
  import rbs_pkg::*;
  logic req;
  assign req = avs_read_i | avs_write_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_take;
    avs_write_i && !avs_waitrequest_o && avs_address_i == RBS_REG_CMD
      && avs_byteenable_i[0];
  endsequence
  sequence s_op(logic [2:0] c);
    s_take ##0 avs_writedata_i[2:0] == c;
  endsequence
  sequence s_pulse;
    busy_o ##1 !busy_o;
  endsequence
  property p_rst;
    $fell(srst_i) |-> acc_o == RBS_ACC_RST && flags_o == RBS_FLG_RST
      && !busy_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // a held request is answered within two cycles, even behind a command
  property p_wait;
    req && avs_waitrequest_o |=> ##[0:1] !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest too long");
  property p_pulse;
    s_take ##0 avs_writedata_i[2:0] < RBS_OP_COUNT |=> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("busy pulse wrong");
  property p_r1;
    s_op(RBS_OP_ROT_COPY) |=> $stable(flags_o) [*2];
  endproperty
  a_r1: assert property (p_r1)
    else $error("rotate copy moved flags");
  property p_r2;
    s_op(RBS_OP_ROT_CARRY) |=> ($stable(acc_o) && $stable(flags_o[3:1])) [*2];
  endproperty
  a_r2: assert property (p_r2)
    else $error("rotate carry side effect");
  property p_r3;
    s_op(RBS_OP_ROT_CARRY_COPY) |=> $stable(flags_o[3:1]) [*2];
  endproperty
  a_r3: assert property (p_r3)
    else $error("carry copy moved flags");
  property p_r6;
    s_op(RBS_OP_SUB_BORROW_MEM) |=> $stable(acc_o) [*2];
  endproperty
  a_r6: assert property (p_r6)
    else $error("memory subtract hit acc");
  property p_z;
    s_op(RBS_OP_SUB_BORROW) |-> ##2 flags_o[RBS_FLG_Z] == (acc_o == 8'h00);
  endproperty
  a_z: assert property (p_z)
    else $error("zero flag wrong");
endmodule

bind rbs_core rbs_core_chk u_chk
(
  .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .acc_o(acc_o), .flags_o(flags_o), .busy_o(busy_o)
);

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import rbs_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [RBS_ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] acc_o;
  logic [3:0] flags_o;
  logic busy_o;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic [31:0] rnd = 32'h477d;
  // 32-bit maximal-length shift register, one step per call
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  rbs_core uut
  (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .acc_o(acc_o), .flags_o(flags_o), .busy_o(busy_o)
  );
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out();
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // waitrequest is read as it stood just before each rising edge, so the
  // release falls on the edge that completes the transfer
  task automatic bus(input logic rd, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    bus(1'b1, a, 32'h0, 4'hf);
  endtask
  always @(posedge clk_i)
  begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
    begin
      samples_checked++;
      if (avs_readdata_o !== exp_q[0])
      begin
        errors++;
        $display("Error %s expected %h seen %h", name_q[0], exp_q[0],
                 avs_readdata_o);
      end
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
    end
  end
  initial
  begin
    #100000;
    errors++;
    $display("Error watchdog expected %s seen %s", "done", "hang");
    close_out();
  end
  initial
  begin
    logic [7:0] a, m, ea, em;
    logic [3:0] f, ef;
    logic [5:0] ix;
    logic [2:0] op;
    logic [8:0] d9;
    logic [4:0] n5;
    logic bad;
    logic [9:0] ma;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(RBS_REG_FLAGS, 32'h0, "flags_rst");
    rd(RBS_MEM_BASE + 10'h0fc, 32'h0, "mem_rst");
    bus(1'b0, RBS_REG_ACC, 32'h5a, 4'he);
    rd(RBS_REG_ACC, 32'h0, "acc_lane");
    rd(10'h3f0, 32'h0, "unmapped");
    for (int k = 0; k < 64; k++)
    begin
      rnd = lfsr(rnd);
      {ix, f, m, a} = {rnd[29:24], rnd[19:16], rnd[15:8], rnd[7:0]};
      ma = RBS_MEM_BASE + {2'b0, ix, 2'b0};
      op = 3'(k % 8);
      bus(1'b0, RBS_REG_ACC, {24'h0, a}, 4'hf);
      bus(1'b0, RBS_REG_FLAGS, {28'h0, f}, 4'hf);
      bus(1'b0, ma, {24'h0, m}, 4'hf);
      bus(1'b0, RBS_REG_CMD, {18'h0, ix, 5'h0, op}, 4'hf);
      {ea, em, ef, bad} = {a, m, f, 1'b0};
      d9 = {1'b0, a} - {1'b0, m} - 9'(!f[0]);
      n5 = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(!f[0]);
      case (op)
        3'h0: ea = {m[0], m[7:1]};
        3'h1: {em, ef[0]} = {f[0], m};
        3'h2: {ea, ef[0]} = {f[0], m};
        3'h3, 3'h4:
        begin
          ef = {(a[7] ^ m[7]) & (a[7] ^ d9[7]), d9[7:0] == 8'h00, !n5[4],
                !d9[8]};
          if (op == 3'h3)
            ea = d9[7:0];
          else
            em = d9[7:0];
        end
        default: bad = 1'b1;
      endcase
      rd(RBS_REG_ACC, {24'h0, ea}, "acc");
      rd(RBS_REG_FLAGS, {28'h0, ef}, "flags");
      rd(ma, {24'h0, em}, "mem");
      rd(RBS_REG_STAT, 32'(bad) << RBS_STAT_BAD, "stat");
    end
    // let the monitor take the last answer before judging the queue
    @(posedge clk_i);
    if (exp_q.size() != 0)
    begin
      errors++;
      $display("Error pending expected %0d seen %0d", 0, exp_q.size());
    end
    close_out();
  end
endmodule
